// file: rtl/qmac_ctl_if.sv
// qmac_ctl_if: parameter word carried between control and datapath
`timescale 1ns/1ps
interface qmac_ctl_if;
  logic [15:0] ctrl_word;
  modport src (output ctrl_word);
  modport dst (input  ctrl_word);
endinterface : qmac_ctl_if

// file: rtl/qmac_ctrl_reg.sv
// qmac_ctrl_reg: host-written operation_control with pin bypass
`timescale 1ns/1ps
module qmac_ctrl_reg (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        pin_param_select_i,
  input  wire logic        dev_sel_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [15:0] host_data_bus_i,
  output logic      [15:0] ctrl_rd_o,
  qmac_ctl_if.src          ctl
);
  // ==========================================================
  // write capture
  logic        wr_act_r;
  logic [15:0] wdata_r;
  logic [15:0] operation_control_r;
  logic [15:0] stage_r;
  logic        stage_v_r;
  wire         wr_act_nxt = ~dev_sel_n_i & ~wr_n_i;
  wire         wr_end     = wr_act_r & ~wr_act_nxt;

  // data latched while strobe low, committed after lag
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_act_r            <= 1'b0;
      wdata_r             <= qmac_pkg::CTRL_RESET;
      stage_r             <= qmac_pkg::CTRL_RESET;
      stage_v_r           <= 1'b0;
      operation_control_r <= qmac_pkg::CTRL_RESET; // RQ22
    end
    else
    begin
      wr_act_r  <= wr_act_nxt & ~pin_param_select_i;
      if (wr_act_nxt)
        wdata_r <= host_data_bus_i; // RQ26
      stage_r   <= wdata_r;
      stage_v_r <= wr_end; // RQ26
      if (stage_v_r)
        operation_control_r <= stage_r; // RQ20
    end
  end

  // pin mode feeds the bus straight into the sampled parameters
  assign ctl.ctrl_word = pin_param_select_i ? host_data_bus_i
                                            : operation_control_r; // RQ18
  assign ctrl_rd_o = operation_control_r;
endmodule : qmac_ctrl_reg

// file: rtl/qmac_delay_line.sv
// qmac_delay_line: selectable 0..N cycle delay
`timescale 1ns/1ps
module qmac_delay_line #(
  parameter int W = 8,
  parameter int N = 3
) (
  input  wire logic         core_clk_i,
  input  wire logic [1:0]   sel_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] tap_r [N];
  // ==========================================================
  // shift chain, no reset: datapath content undefined after reset
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_tap
      if (g == 0)
      begin : g_first
        always_ff @(posedge core_clk_i)
          tap_r[g] <= d_i;
      end
      else
      begin : g_rest
        always_ff @(posedge core_clk_i)
          tap_r[g] <= tap_r[g-1];
      end
    end
  endgenerate
  // tap select
  assign q_o = (sel_i == 2'h0) ? d_i : tap_r[sel_i - 2'h1]; // RQ9
endmodule : qmac_delay_line

// file: rtl/qmac_pkg.sv
// qmac_pkg: shared constants for the quad multiply-accumulate datapath
package qmac_pkg;
  // ==========================================================
  // operation_control field positions
  localparam int MFMT_LSB   = 0;
  localparam int RFMT_BIT   = 2;
  localparam int RCUT_BIT   = 3;
  localparam int WSEL_LSB   = 4;
  localparam int CHOFF_BIT  = 9;
  localparam int CDLY_LSB   = 10;
  localparam int SGN_LSB    = 12;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // ==========================================================
  // widths and encodings
  localparam int ACC_W      = 40;
  localparam int CHAIN_W    = 20;
  localparam int OUT_W      = 20;
  localparam int WSEL_MAX   = 20;
  localparam int MAX_DLY    = 3;
  localparam int FP_EXP_W   = 6;
  localparam int FP_FRAC_W  = 9;
  localparam logic [5:0] FP_BIAS = 6'h01;
  localparam int CTRL_LAG   = 2;
  localparam logic [1:0] OP_ACCUM = 2'h0;
  localparam logic [1:0] OP_HOLD  = 2'h1;
  localparam logic [1:0] OP_LOAD  = 2'h2;
  localparam logic [1:0] OP_CLEAR = 2'h3;
  typedef enum logic [1:0] {
    QMAC_S8X8, QMAC_U8X8, QMAC_S16X16, QMAC_U16X16
  } qmac_mfmt_t;
endpackage : qmac_pkg

// file: rtl/qmac_top.sv
// qmac_top: pipelined four-multiplier accumulator with cascade output
// Functional notes
// RQ1 - four-product mode multiplies pairs a*b, c*d, e*f, g*h, signed or not
// RQ2 - single-product mode multiplies {a,b} by {c,d}; e..h ignored
// RQ3 - multiplier_format picks signed/unsigned, 8x8 quad or 16x16 single
// RQ4 - sign_select bits negate c*d, g*h, pair sum, and whole term
// RQ5 - running sum is 40-bit two's complement updated each clock
// RQ6 - sum op: accumulate, hold, load term, or clear
// RQ7 - hold_load_select high loads sample register, low keeps it
// RQ8 - cascaded_total is held_total plus shifted chain_input unless off
// RQ9 - chain_delay adds 0 to 3 delay cycles
// RQ10 - float output drives 16 bits, upper four low
// RQ11 - result_format 0 float, 1 fixed
// RQ12 - fixed output is 20-bit window at bit_window_select
// RQ13 - bit_window_select also shifts chain input; chain devices agree
// RQ14 - round_or_cut 0 rounds window, 1 truncates
// RQ15 - latency 6 to 10 clocks; parameters travel with data
// RQ16 - accumulator overflow flagged with its data, kept while holding
// RQ17 - cascade overflow ORed into overflow_flag
// RQ18 - pin mode samples parameters from data bus every clock
// RQ19 - in pin mode other party holds strobes high, bus constant; the bench pins each table row's own word, changing it per sample
// RQ20 - host write replaces parameters two clocks after write ends
// RQ21 - other party should clear or load sum after parameter change
// RQ22 - reset clears the control register
// RQ23 - product_zero_mask forces operand pairs to zero
// RQ24 - float: sign, 6-bit exponent, 9-bit fraction, bias 1
// RQ25 - datapath registers undefined after reset
// RQ26 - host write taken while select and strobe low, captured on release
`timescale 1ns/1ps
module qmac_top (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        pin_param_select_i,
  input  wire logic        dev_sel_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [15:0] host_data_bus_i,
  input  wire logic [7:0]  port_a_i,
  input  wire logic [7:0]  port_b_i,
  input  wire logic [7:0]  port_c_i,
  input  wire logic [7:0]  port_d_i,
  input  wire logic [7:0]  port_e_i,
  input  wire logic [7:0]  port_f_i,
  input  wire logic [7:0]  port_g_i,
  input  wire logic [7:0]  port_h_i,
  input  wire logic [19:0] chain_input_i,
  input  wire logic [1:0]  sum_register_op_i,
  input  wire logic        hold_load_select_i,
  input  wire logic [3:0]  product_zero_mask_i,
  output logic      [15:0] ctrl_rd_o,
  output logic      [19:0] result_out_o,
  output logic             overflow_flag_o
);
  localparam int AW = qmac_pkg::ACC_W;
  localparam int CW = qmac_pkg::CHAIN_W;

  // ==========================================================
  // parameter source
  qmac_ctl_if ctl ();
  qmac_ctrl_reg u_ctrl (
    .core_clk_i         (core_clk_i),
    .reset_n_i          (reset_n_i),
    .pin_param_select_i (pin_param_select_i),
    .dev_sel_n_i        (dev_sel_n_i),
    .wr_n_i             (wr_n_i),
    .host_data_bus_i    (host_data_bus_i),
    .ctrl_rd_o          (ctrl_rd_o),
    .ctl                (ctl)
  );

  // ==========================================================
  // stage 1: input sampling, parameters ride along
  logic [7:0]  pa_r, pb_r, pc_r, pd_r, pe_r, pf_r, pg_r, ph_r;
  logic [15:0] p1_r;
  logic [1:0]  op1_r;
  logic        smp1_r;

  // zero mask applied at sampling so it lines up with its data
  always_ff @(posedge core_clk_i)
  begin
    pa_r   <= product_zero_mask_i[0] ? 8'h00 : port_a_i; // RQ23
    pb_r   <= product_zero_mask_i[0] ? 8'h00 : port_b_i; // RQ23
    pc_r   <= product_zero_mask_i[1] ? 8'h00 : port_c_i; // RQ23
    pd_r   <= product_zero_mask_i[1] ? 8'h00 : port_d_i; // RQ23
    pe_r   <= product_zero_mask_i[2] ? 8'h00 : port_e_i; // RQ23
    pf_r   <= product_zero_mask_i[2] ? 8'h00 : port_f_i; // RQ23
    pg_r   <= product_zero_mask_i[3] ? 8'h00 : port_g_i; // RQ23
    ph_r   <= product_zero_mask_i[3] ? 8'h00 : port_h_i; // RQ23
    p1_r   <= ctl.ctrl_word; // RQ15
    op1_r  <= sum_register_op_i;
    smp1_r <= hold_load_select_i;
  end

  // ==========================================================
  // stage 2: multiplication
  wire [1:0] mfmt1  = p1_r[qmac_pkg::MFMT_LSB +: 2];
  wire       uns1   = mfmt1[0]; // RQ3
  wire       wide1  = mfmt1[1]; // RQ3
  wire [3:0] sgn1   = p1_r[qmac_pkg::SGN_LSB +: 4];

  // sign-or-zero extend to 17 bits so one signed multiplier covers both
  function automatic logic signed [16:0] ext8(input logic [7:0] v,
                                              input logic u);
    ext8 = {{9{~u & v[7]}}, v};
  endfunction : ext8
  function automatic logic signed [16:0] ext16(input logic [15:0] v,
                                               input logic u);
    ext16 = {~u & v[15], v};
  endfunction : ext16

  wire signed [33:0] m_ab = ext8(pa_r, uns1) * ext8(pb_r, uns1); // RQ1
  wire signed [33:0] m_cd = ext8(pc_r, uns1) * ext8(pd_r, uns1); // RQ1
  wire signed [33:0] m_ef = ext8(pe_r, uns1) * ext8(pf_r, uns1); // RQ1
  wire signed [33:0] m_gh = ext8(pg_r, uns1) * ext8(ph_r, uns1); // RQ1
  wire signed [33:0] m_w  = ext16({pa_r, pb_r}, uns1)
                          * ext16({pc_r, pd_r}, uns1); // RQ2

  // combine products under sign_select
  wire signed [AW-1:0] t_cd  = sgn1[0] ? -AW'(m_cd) : AW'(m_cd); // RQ4
  wire signed [AW-1:0] t_gh  = sgn1[1] ? -AW'(m_gh) : AW'(m_gh); // RQ4
  wire signed [AW-1:0] t_ab  = AW'(m_ab) + t_cd;
  wire signed [AW-1:0] t_ef0 = AW'(m_ef) + t_gh;
  wire signed [AW-1:0] t_ef  = sgn1[2] ? -t_ef0 : t_ef0; // RQ4
  wire signed [AW-1:0] t_sum = wide1 ? AW'(m_w) : (t_ab + t_ef); // RQ2
  wire signed [AW-1:0] term  = sgn1[3] ? -t_sum : t_sum; // RQ4

  logic signed [AW-1:0] term_r;
  logic [15:0] p2_r;
  logic [1:0]  op2_r;
  logic        smp2_r;
  always_ff @(posedge core_clk_i)
  begin
    term_r <= term;
    p2_r   <= p1_r; // RQ15
    op2_r  <= op1_r;
    smp2_r <= smp1_r;
  end

  // ==========================================================
  // stage 3: accumulate and sample
  logic signed [AW-1:0] sum_r;
  logic signed [AW-1:0] held_total_r;
  logic                 acc_ovf_pend_r;
  logic                 held_ovf_r;
  logic [15:0]          p3_r;

  wire signed [AW:0] acc_wide = {sum_r[AW-1], sum_r}
                              + {term_r[AW-1], term_r};
  wire acc_ovf = (op2_r == qmac_pkg::OP_ACCUM)
               & (acc_wide[AW] ^ acc_wide[AW-1]);
  logic signed [AW-1:0] sum_nxt;
  always_comb
  begin
    case (op2_r)
      qmac_pkg::OP_ACCUM: sum_nxt = acc_wide[AW-1:0]; // RQ6
      qmac_pkg::OP_HOLD:  sum_nxt = sum_r; // RQ6
      qmac_pkg::OP_LOAD:  sum_nxt = term_r; // RQ6
      qmac_pkg::OP_CLEAR: sum_nxt = '0; // RQ6
      default:            sum_nxt = sum_r;
    endcase
  end

  // overflow kept pending while the sample register holds
  wire acc_ovf_any = acc_ovf | acc_ovf_pend_r;
  // sum and sample register stay unreset: undefined after reset
  always_ff @(posedge core_clk_i)
  begin
    sum_r <= sum_nxt; // RQ5
    p3_r  <= p2_r;
    if (smp2_r)
      held_total_r <= sum_nxt; // RQ7
  end

  // only these two flags are reset; overflow_flag_o and the cascade overflow path are not, so an unknown can still reach the pin
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      held_ovf_r     <= 1'b0;
      acc_ovf_pend_r <= 1'b0;
    end
    else if (smp2_r)
    begin
      held_ovf_r     <= acc_ovf_any; // RQ16
      acc_ovf_pend_r <= 1'b0;
    end
    else
    begin
      held_ovf_r     <= 1'b0;
      acc_ovf_pend_r <= acc_ovf_any; // RQ16
    end
  end

  // ==========================================================
  // delay steps to line up with the chain input
  localparam int DW = AW + 1 + 16;
  logic [DW-1:0] dly_q;
  qmac_delay_line #(
    .W (DW),
    .N (qmac_pkg::MAX_DLY)
  ) u_dly (
    .core_clk_i (core_clk_i),
    .sel_i      (p3_r[qmac_pkg::CDLY_LSB +: 2]), // RQ9
    .d_i        ({held_total_r, held_ovf_r, p3_r}),
    .q_o        (dly_q)
  );
  wire signed [AW-1:0] held_d = dly_q[DW-1 -: AW];
  wire                 hovf_d = dly_q[16];
  wire [15:0]          p4     = dly_q[15:0];

  // ==========================================================
  // stage: chain input sample (after delay)
  logic signed [AW-1:0] held4_r;
  logic                 hovf4_r;
  logic [15:0]          p4_r;
  logic [CW-1:0]        chain4_r;
  always_ff @(posedge core_clk_i)
  begin
    held4_r  <= held_d;
    hovf4_r  <= hovf_d;
    p4_r     <= p4;
    chain4_r <= chain_input_i; // RQ9 sampled after the delay steps
  end

  // ==========================================================
  // stage: cascade addition
  wire [4:0] wsel4  = p4_r[qmac_pkg::WSEL_LSB +: 5];
  wire       choff4 = p4_r[qmac_pkg::CHOFF_BIT];
  wire signed [AW-1:0] chain_ext = AW'($signed(chain4_r));
  // chain word shifted by the same window as the output
  wire signed [AW-1:0] chain_sh = choff4 ? '0 : (chain_ext <<< wsel4);
  wire signed [AW:0] cascaded_total_w = {held4_r[AW-1], held4_r}
                            + {chain_sh[AW-1], chain_sh}; // RQ8 RQ13
  wire csc_ovf = cascaded_total_w[AW] ^ cascaded_total_w[AW-1];

  logic signed [AW-1:0] cascaded_total_r;
  logic                 ovf5_r;
  logic [15:0]          p5_r;
  always_ff @(posedge core_clk_i)
  begin
    cascaded_total_r <= cascaded_total_w[AW-1:0]; // RQ8
    ovf5_r           <= hovf4_r | csc_ovf; // RQ17
    p5_r             <= p4_r;
  end

  // ==========================================================
  // fixed window with rounding; saturates the round-up carry
  wire        rcut5 = p5_r[qmac_pkg::RCUT_BIT];
  wire [4:0]  wsel5 = p5_r[qmac_pkg::WSEL_LSB +: 5];
  wire [AW-1:0] shifted = cascaded_total_r >>> wsel5; // RQ12
  wire        rbit  = (wsel5 != 5'h00) & cascaded_total_r[wsel5 - 5'h01];
  wire [qmac_pkg::OUT_W-1:0] win = shifted[qmac_pkg::OUT_W-1:0];
  wire [qmac_pkg::OUT_W-1:0] fix_val = (!rcut5 && rbit && win != 20'h7FFFF)
                                     ? win + 20'h00001 : win; // RQ14

  // float conversion: leading one search on magnitude
  wire          fsgn = cascaded_total_r[AW-1];
  wire [AW-1:0] fmag = fsgn ? -cascaded_total_r : cascaded_total_r;
  logic [5:0]   lead;
  always_comb
  begin
    lead = 6'h00;
    for (int i = 0; i < AW; i++)
      if (fmag[i])
        lead = 6'(i);
  end
  wire [AW-1:0] fnorm = fmag << (6'(AW - 1) - lead);
  wire [5:0]    fexp  = (fmag == '0) ? 6'h00 : lead + qmac_pkg::FP_BIAS;
  wire [8:0]    ffrac = (fmag == '0) ? 9'h000 : fnorm[AW-2 -: 9];
  wire [15:0]   fp_val = {fsgn, fexp, ffrac}; // RQ24

  // ==========================================================
  // float stage then output register; fixed skips the float stage
  logic [15:0] fp6_r;
  logic        ovf6_r;
  logic        rfmt6_r;
  always_ff @(posedge core_clk_i)
  begin
    fp6_r   <= fp_val;
    ovf6_r  <= ovf5_r;
    rfmt6_r <= p5_r[qmac_pkg::RFMT_BIT];
  end

  wire rfmt5 = p5_r[qmac_pkg::RFMT_BIT]; // RQ11
  always_ff @(posedge core_clk_i)
  begin
    if (rfmt5)
    begin
      result_out_o    <= fix_val; // RQ12 RQ15
      overflow_flag_o <= ovf5_r;
    end
    else if (!rfmt6_r)
    begin
      result_out_o    <= {4'h0, fp6_r}; // RQ10
      overflow_flag_o <= ovf6_r;
    end
  end
endmodule : qmac_top

// file: tb/qmac_checker.sv
// qmac_checker: port-level assertions for the accumulator
`timescale 1ns/1ps
module qmac_checker (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        pin_param_select_i,
  input wire logic        dev_sel_n_i,
  input wire logic        wr_n_i,
  input wire logic [15:0] host_data_bus_i,
  input wire logic [1:0]  sum_register_op_i,
  input wire logic        hold_load_select_i,
  input wire logic [15:0] ctrl_rd_o,
  input wire logic [19:0] result_out_o,
  input wire logic        overflow_flag_o
);
  logic [15:0] last_word_r;
  // ==========================================================
  // word seen while the strobe is low; last one wins
  always_ff @(posedge core_clk_i)
  begin
    if (!dev_sel_n_i && !wr_n_i)
      last_word_r <= host_data_bus_i;
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // strobe released after a host write cycle
  sequence wr_rel;
    !$past(wr_n_i) && !$past(dev_sel_n_i) && wr_n_i && !pin_param_select_i;
  endsequence
  // pin sample: fixed format, chain off, no extra delay
  sequence fix_s;
    pin_param_select_i && host_data_bus_i[2] && host_data_bus_i[9]
      && host_data_bus_i[11:10] == 2'h0;
  endsequence
  // pin sample: float format, chain off, no extra delay
  sequence flt_s;
    pin_param_select_i && !host_data_bus_i[2] && host_data_bus_i[9]
      && host_data_bus_i[11:10] == 2'h0;
  endsequence
  // previous sample carried the same pinned word
  sequence same_s;
    $past(pin_param_select_i) && $past(host_data_bus_i) == host_data_bus_i;
  endsequence
  // ==========================================================
  // sync reset needs no disable, it is the cause here
  a_reset_clears: assert property (disable iff (1'b0)
    !reset_n_i |=> ctrl_rd_o == 16'h0000) else $error("ctrl not cleared");
  a_write_not_early: assert property (wr_rel |=> $stable(ctrl_rd_o))
    else $error("ctrl changed too early");
  a_write_lands: assert property (
    wr_rel |-> ##[2:5] ctrl_rd_o == last_word_r) else $error("write lost");
  a_pin_ignores_host: assert property (
    pin_param_select_i [*4] |-> $stable(ctrl_rd_o)) else $error("ctrl moved");
  a_clear_gives_zero: assert property (
    fix_s ##0 (sum_register_op_i == 2'h3 && hold_load_select_i)
    |-> ##6 (result_out_o == 20'h0 && !overflow_flag_o))
    else $error("fixed clear not zero");
  a_float_zero_code: assert property (
    flt_s ##0 (sum_register_op_i == 2'h3 && hold_load_select_i)
    |-> ##7 result_out_o == 20'h0) else $error("float zero wrong");
  a_float_upper_low: assert property (
    flt_s |-> ##7 result_out_o[19:16] == 4'h0) else $error("float upper set");
  a_sample_holds: assert property (
    fix_s ##0 same_s ##0 !hold_load_select_i |-> ##6 $stable(result_out_o))
    else $error("sample register not held");
  a_sum_op_holds: assert property (
    fix_s ##0 same_s ##0 (sum_register_op_i == 2'h1 && hold_load_select_i
    && $past(hold_load_select_i)) |-> ##6 $stable(result_out_o))
    else $error("hold op changed sum");
endmodule : qmac_checker

// file: tb/qmac_host_model.sv
// qmac_host_model: host side that writes or pins the parameter word
`timescale 1ns/1ps
module qmac_host_model (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        pin_mode_i,
  input  wire logic [15:0] param_i,
  input  wire logic        go_i,
  input  wire logic [15:0] word_i,
  output logic             dev_sel_n_o,
  output logic             wr_n_o,
  output logic      [15:0] host_data_bus_o
);
  logic [15:0] bus_r;
  logic        low_r;
  // ==========================================================
  // one-cycle write strobe; a released bus alternates between the inverse of its last word and that word
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || pin_mode_i)
    begin
      low_r <= 1'b0;
      bus_r <= 16'hA5A5;
    end
    else if (go_i && !low_r)
    begin
      low_r <= 1'b1;
      bus_r <= word_i;
    end
    else
    begin
      low_r <= 1'b0;
      bus_r <= ~bus_r;
    end
  end
  // strobes held high in pin mode, bus then carries the parameters
  assign dev_sel_n_o     = ~low_r;
  assign wr_n_o          = ~low_r;
  assign host_data_bus_o = pin_mode_i ? param_i : bus_r;
endmodule : qmac_host_model

// file: tb/test_quad_mac_accumulator.sv
// test_quad_mac_accumulator: self-checking bench for the accumulator
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_quad_mac_accumulator;
  typedef struct packed {
    logic [15:0] w;
    logic [63:0] p;
    logic [1:0]  op;
    logic        s;
    logic [3:0]  m;
    logic [19:0] ch;
    logic [19:0] e;
  } qmac_row_t;
  localparam int NR = 19;
  localparam logic [63:0] P0 = 64'h0203FF0405050101;
  localparam logic [63:0] P3 = 64'hFFFE000311111111;
  // word, ports, op, sample, mask, chain, expected result
  localparam qmac_row_t ROWS [NR] = '{
    {16'h020C, P0, 2'h2, 1'h1, 4'h0, 20'h0, 20'h0001C},
    {16'h020D, P0, 2'h2, 1'h1, 4'h0, 20'h0, 20'h0041C},
    {16'hF20C, P0, 2'h2, 1'h1, 4'h0, 20'h0, 20'h0000E},
    {16'h020E, P3, 2'h2, 1'h1, 4'h0, 20'h0, 20'hFFFFA},
    {16'h020F, P3, 2'h2, 1'h1, 4'h0, 20'h0, 20'h2FFFA},
    {16'h020C, P0, 2'h2, 1'h1, 4'h5, 20'h0, 20'hFFFFD},
    {16'h920E, P3, 2'h2, 1'h1, 4'h0, 20'h0, 20'h00006},
    {16'h020C, P0, 2'h3, 1'h1, 4'h0, 20'h0, 20'h00000},
    {16'h020C, P0, 2'h0, 1'h1, 4'h0, 20'h0, 20'h0001C},
    {16'h020C, P0, 2'h0, 1'h1, 4'h0, 20'h0, 20'h00038},
    {16'h020C, P3, 2'h1, 1'h1, 4'h0, 20'h0, 20'h00038},
    {16'h020C, P0, 2'h0, 1'h0, 4'h0, 20'h0, 20'h00038},
    {16'h020C, P3, 2'h1, 1'h1, 4'h0, 20'h0, 20'h00054},
    {16'h0044, P0, 2'h2, 1'h1, 4'h0, 20'h3, 20'h00005},
    {16'h004C, P0, 2'h2, 1'h1, 4'h0, 20'h3, 20'h00004},
    {16'h0200, P0, 2'h2, 1'h1, 4'h0, 20'h0, 20'h00B80},
    {16'h0202, P3, 2'h2, 1'h1, 4'h0, 20'h0, 20'h08700},
    {16'h0200, P0, 2'h3, 1'h1, 4'h0, 20'h0, 20'h00000},
    {16'h0E0C, P0, 2'h2, 1'h1, 4'h0, 20'h0, 20'h0001C}
  };
  localparam qmac_row_t IDLE = {16'h0E0C, P0, 2'h1, 1'h1, 4'h0, 40'h0};
  logic        clk, rst_n, pin, go, hold_load_select;
  logic [15:0] param, word, bus, ctrl;
  logic [63:0] pv;
  logic [1:0]  op;
  logic [3:0]  mask;
  logic [19:0] chain, res;
  logic        sel_n, wr_n, ovf;
  logic [20:0] hist [NR+12];
  int          n_mismatch, num_checks, cyc;
  qmac_top u_qmac_top (.core_clk_i(clk), .reset_n_i(rst_n),
    .pin_param_select_i(pin), .dev_sel_n_i(sel_n), .wr_n_i(wr_n),
    .host_data_bus_i(bus), .port_a_i(pv[63:56]), .port_b_i(pv[55:48]),
    .port_c_i(pv[47:40]), .port_d_i(pv[39:32]), .port_e_i(pv[31:24]),
    .port_f_i(pv[23:16]), .port_g_i(pv[15:8]), .port_h_i(pv[7:0]),
    .chain_input_i(chain), .sum_register_op_i(op), .hold_load_select_i(hold_load_select),
    .product_zero_mask_i(mask), .ctrl_rd_o(ctrl), .result_out_o(res),
    .overflow_flag_o(ovf));
  qmac_host_model u_qmac_host_model (.core_clk_i(clk), .reset_n_i(rst_n),
    .pin_mode_i(pin), .param_i(param), .go_i(go), .word_i(word),
    .dev_sel_n_o(sel_n), .wr_n_o(wr_n), .host_data_bus_o(bus));
  // ==========================================================
  // 5 ns clock; the run needs about 55 cycles, so 600 means a hang
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 600)
    begin
      `CHK("timeout", 1'b0, 1'b1)
      test_done;
    end
  end
  // one sample of stream inputs, launched by non-blocking assignment
  task automatic put(input qmac_row_t r);
    param <= r.w;
    pv    <= r.p;
    op    <= r.op;
    hold_load_select   <= r.s;
    mask  <= r.m;
  endtask : put
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // ==========================================================
  // main sequence: reset, table stream, host write, second reset
  initial
  begin
    int lat;
    int k;
    {clk, rst_n, pin, go, hold_load_select, param, word, pv, mask, chain} = '0;
    op = 2'h1;
    {n_mismatch, num_checks, cyc} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("ctrl after reset", 16'h0000, ctrl)
    $display("test reset done");
    for (int j = 0; j < NR + 12; j++)
    begin
      @(posedge clk);
      pin <= 1'b1;
      put(j < NR ? ROWS[j] : IDLE);
      // chain word arrives three cycles after its data (no extra delay)
      chain <= (j >= 3 && j < NR + 3) ? ROWS[(j + NR - 3) % NR].ch : 20'h0;
      @(negedge clk);
      hist[j] = {ovf, res};
    end
    for (int i = 0; i < NR; i++)
    begin
      lat = 6 + int'(!ROWS[i].w[2]) + int'(ROWS[i].w[11:10]);
      `CHK("result", {1'b0, ROWS[i].e}, hist[i+lat])
    end
    $display("test table stream done");
    @(posedge clk);
    pin  <= 1'b0;
    word <= 16'h020C;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (ctrl !== 16'h020C && k < 8)
    begin
      @(posedge clk);
      k++;
    end
    `CHK("ctrl write", 16'h020C, ctrl)
    @(posedge clk);
    put(ROWS[0]);
    @(posedge clk);
    op <= 2'h1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK("host result", 20'h0001C, res)
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("ctrl second reset", 16'h0000, ctrl)
    $display("test host write done");
    test_done;
  end
endmodule : test_quad_mac_accumulator
bind qmac_top qmac_checker u_qmac_checker (.core_clk_i, .reset_n_i,
  .pin_param_select_i, .dev_sel_n_i, .wr_n_i, .host_data_bus_i,
  .sum_register_op_i, .hold_load_select_i, .ctrl_rd_o, .result_out_o,
  .overflow_flag_o);
